/* rtl/ubs_params.svh */
`ifndef UBS_PARAMS_SVH
`define UBS_PARAMS_SVH
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// - timed shutdown only in host-selector position
// - mains back during delay: output kept, request idle
// - delay time five to 65535 seconds
// - request held for shutdown time, output powered
// - mains back before waiting: output off waiting time
// - mains still absent: full power-down until return
// - open inhibit contacts disable buffer mode outside the request phase
// - open inhibit in normal: fault, red steady, alarm
// - battery below cut-off ends buffering, output off
// - flashing continues until battery under floor
// - after cut-off, only mains return re-enables
// - battery below warning level: yellow blinks 4 Hz
// - mains below activation threshold enters buffer
// - buffer mode: yellow blinks about 2 Hz
`define UBS_CLK_HZ 32'd50000000
`define UBS_SEC_CYCLES (`UBS_CLK_HZ)
`define UBS_BLINK2_HZ 32'd2
`define UBS_BLINK4_HZ 32'd4
// half period of a blink, in cycles
`define UBS_HALF2_CYCLES (`UBS_CLK_HZ / (2 * `UBS_BLINK2_HZ))
`define UBS_HALF4_CYCLES (`UBS_CLK_HZ / (2 * `UBS_BLINK4_HZ))
`define UBS_DELAY_MIN 16'h0005
`define UBS_DELAY_RST 16'h0005
`define UBS_SHUT_RST 16'h0000
`define UBS_WAIT_RST 16'h0000
`endif

/* rtl/ubs_pkg.sv */
package ubs_pkg;
    typedef enum logic [2:0] {
        ST_MAINS, ST_BUFFER, ST_DELAY, ST_SHUTREQ, ST_WAIT, ST_CUTOFF, ST_OFF
    } ubs_state_t;
endpackage : ubs_pkg

/* rtl/ubs_sequencer.sv */
`timescale 1ns/1ps
`include "ubs_params.svh"
module ubs_sequencer #(
    parameter int SEC_CYCLES = `UBS_SEC_CYCLES,
    parameter int HALF2_CYCLES = `UBS_HALF2_CYCLES,
    parameter int HALF4_CYCLES = `UBS_HALF4_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // comparator results and contacts (asynchronous)
    input wire logic mainsBelowActivation,
    input wire logic batBelowCutoff,
    input wire logic batBelowFloor,
    input wire logic batBelowWarn,
    input wire logic hostShutdownSelectorPosition,
    input wire logic remoteInhibitContactsClosed,
    // configuration, seconds
    input wire logic [15:0] delaySeconds,
    input wire logic [15:0] shutdownSeconds,
    input wire logic [15:0] waitSeconds,
    // outputs
    output logic outputEnable,
    output logic shutdownRequest,
    output logic alarmContactOpen,
    output logic redLed,
    output logic yellowLed,
    output logic noBufferFault,
    output logic powerDown
);
    //------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------
    logic [5:0] syncA;
    logic [5:0] syncB;
    // two flops per pin; only syncB is read by logic
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            // idle levels: link closed, so no false fault pulse at release
            syncA <= 6'h01;
            syncB <= 6'h01;
        end else begin
            syncA <= {mainsBelowActivation, batBelowCutoff, batBelowFloor,
                      batBelowWarn, hostShutdownSelectorPosition,
                      remoteInhibitContactsClosed};
            syncB <= syncA;
        end
    end
    logic mainsLow, batCut, batFloor, batWarn, hostMode, inhibitClosed;
    assign {mainsLow, batCut, batFloor, batWarn, hostMode, inhibitClosed} = syncB;

    //------------------------------------------------------------
    // ticks
    //------------------------------------------------------------
    logic secTick, tick2, tick4;
    ubs_tick_gen #(.PERIOD(SEC_CYCLES)) u_sec (
        .clock(clock), .nrst(nrst), .tick(secTick));
    ubs_tick_gen #(.PERIOD(HALF2_CYCLES)) u_b2 (
        .clock(clock), .nrst(nrst), .tick(tick2));
    ubs_tick_gen #(.PERIOD(HALF4_CYCLES)) u_b4 (
        .clock(clock), .nrst(nrst), .tick(tick4));

    // delay below the minimum is raised to the minimum
    function automatic logic [15:0] clampDelay(input logic [15:0] v);
        clampDelay = (v < `UBS_DELAY_MIN) ? `UBS_DELAY_MIN : v;
    endfunction : clampDelay

    //------------------------------------------------------------
    // state machine
    //------------------------------------------------------------
    ubs_pkg::ubs_state_t state, next_state;
    logic [15:0] secCount;
    logic mainsBack;
    logic expired;
    assign expired = secTick && (secCount == 16'h0);

    // next state
    always_comb begin
        next_state = state;
        case (state)
            ubs_pkg::ST_MAINS: begin
                if (mainsLow && inhibitClosed) begin
                    next_state = hostMode ? ubs_pkg::ST_DELAY : ubs_pkg::ST_BUFFER;
                end
            end
            ubs_pkg::ST_BUFFER: begin
                if (!mainsLow) next_state = ubs_pkg::ST_MAINS;
                else if (!inhibitClosed) next_state = ubs_pkg::ST_MAINS;
                else if (batCut) next_state = ubs_pkg::ST_CUTOFF;
            end
            ubs_pkg::ST_DELAY: begin
                if (!mainsLow) next_state = ubs_pkg::ST_MAINS;
                else if (!inhibitClosed) next_state = ubs_pkg::ST_MAINS;
                else if (batCut) next_state = ubs_pkg::ST_CUTOFF;
                else if (expired) next_state = ubs_pkg::ST_SHUTREQ;
            end
            ubs_pkg::ST_SHUTREQ: begin
                if (batCut && mainsLow) next_state = ubs_pkg::ST_CUTOFF;
                else if (expired || shutdownSeconds == 16'h0) begin
                    next_state = (mainsBack || !mainsLow) ? ubs_pkg::ST_WAIT
                                                          : ubs_pkg::ST_OFF;
                end
            end
            ubs_pkg::ST_WAIT: begin
                if (expired || waitSeconds == 16'h0) next_state = ubs_pkg::ST_MAINS;
            end
            ubs_pkg::ST_CUTOFF: begin
                if (!mainsLow) next_state = ubs_pkg::ST_MAINS;
                else if (batFloor) next_state = ubs_pkg::ST_OFF;
            end
            ubs_pkg::ST_OFF: begin
                if (!mainsLow) next_state = ubs_pkg::ST_MAINS;
            end
            default: next_state = ubs_pkg::ST_MAINS;
        endcase
    end

    // state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) state <= ubs_pkg::ST_MAINS;
        else state <= next_state;
    end

    // phase second counter, loaded on phase entry
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            secCount <= 16'h0;
        end else if (next_state != state) begin
            case (next_state)
                ubs_pkg::ST_DELAY: secCount <= clampDelay(delaySeconds) - 16'h1;
                ubs_pkg::ST_SHUTREQ: secCount <= shutdownSeconds - 16'h1;
                ubs_pkg::ST_WAIT: secCount <= waitSeconds - 16'h1;
                default: secCount <= 16'h0;
            endcase
        end else if (secTick && secCount != 16'h0) begin
            secCount <= secCount - 16'h1;
        end
    end

    // remembers mains return during the shutdown phase
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) mainsBack <= 1'b0;
        else if (state != ubs_pkg::ST_SHUTREQ) mainsBack <= 1'b0;
        else if (!mainsLow) mainsBack <= 1'b1;
    end

    //------------------------------------------------------------
    // blink generators
    //------------------------------------------------------------
    logic blink2, blink4;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            blink2 <= 1'b0;
            blink4 <= 1'b0;
        end else begin
            if (tick2) blink2 <= !blink2;
            if (tick4) blink4 <= !blink4;
        end
    end

    //------------------------------------------------------------
    // registered outputs
    //------------------------------------------------------------
    logic buffering, faultNow;
    assign buffering = (next_state == ubs_pkg::ST_BUFFER) || (next_state == ubs_pkg::ST_DELAY)
                    || (next_state == ubs_pkg::ST_SHUTREQ);
    // inhibit checked only in normal operation, from mains
    assign faultNow = !inhibitClosed && (next_state == ubs_pkg::ST_MAINS);

    // power path outputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            outputEnable <= 1'b1;
            shutdownRequest <= 1'b0;
            powerDown <= 1'b0;
        end else begin
            outputEnable <= (next_state == ubs_pkg::ST_MAINS) || buffering;
            shutdownRequest <= (next_state == ubs_pkg::ST_SHUTREQ);
            powerDown <= (next_state == ubs_pkg::ST_OFF);
        end
    end

    // indicator outputs; low-battery warning overrides slow blink
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            noBufferFault <= 1'b0;
            alarmContactOpen <= 1'b0;
            redLed <= 1'b0;
            yellowLed <= 1'b0;
        end else begin
            noBufferFault <= faultNow;
            alarmContactOpen <= faultNow;
            redLed <= faultNow;
            if (next_state == ubs_pkg::ST_OFF) yellowLed <= 1'b0;
            else if (batWarn && (buffering || next_state == ubs_pkg::ST_CUTOFF))
                yellowLed <= blink4;
            else if (buffering) yellowLed <= blink2;
            // flashing goes on after cut-off even if the warn comparator chatters
            else if (next_state == ubs_pkg::ST_CUTOFF) yellowLed <= blink2;
            else yellowLed <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_host_only: assert property (state == ubs_pkg::ST_DELAY |->
        $past(hostMode) || $past(state) == ubs_pkg::ST_DELAY)
        else $error("delay without host mode");
    a_delay_mains: assert property (state == ubs_pkg::ST_DELAY && !mainsLow |=>
        state == ubs_pkg::ST_MAINS ##1 outputEnable && !shutdownRequest)
        else $error("mains return in delay mishandled");
    a_delay_min: assert property ($rose(state == ubs_pkg::ST_DELAY) |->
        secCount >= 16'h4)
        else $error("delay below minimum");
    a_req_power: assert property (state == ubs_pkg::ST_SHUTREQ |=>
        shutdownRequest == (state == ubs_pkg::ST_SHUTREQ)
        && (outputEnable || state != ubs_pkg::ST_SHUTREQ))
        else $error("request phase outputs wrong");
    a_wait_off: assert property (state == ubs_pkg::ST_WAIT |-> !outputEnable)
        else $error("output on while waiting");
    a_off_down: assert property (state == ubs_pkg::ST_OFF |->
        powerDown && !outputEnable)
        else $error("power down not shown");
    a_inhibit: assert property (!inhibitClosed && state == ubs_pkg::ST_MAINS |=>
        state == ubs_pkg::ST_MAINS)
        else $error("buffer entered while inhibited");
    a_fault_led: assert property (!inhibitClosed && state == ubs_pkg::ST_MAINS
        && next_state == ubs_pkg::ST_MAINS |=> redLed && alarmContactOpen)
        else $error("inhibit fault not shown");
    a_cutoff: assert property (state == ubs_pkg::ST_BUFFER && mainsLow
        && inhibitClosed && batCut |=> state == ubs_pkg::ST_CUTOFF ##0 !outputEnable)
        else $error("cutoff missed");
    a_cut_hold: assert property (state == ubs_pkg::ST_CUTOFF && mainsLow |=>
        state != ubs_pkg::ST_MAINS)
        else $error("output back without mains");

    c_buffer: cover property (state == ubs_pkg::ST_BUFFER ##1 state == ubs_pkg::ST_CUTOFF);
    c_shutdown: cover property (state == ubs_pkg::ST_SHUTREQ ##1 state == ubs_pkg::ST_WAIT);
    c_off: cover property (state == ubs_pkg::ST_SHUTREQ ##1 state == ubs_pkg::ST_OFF);
    c_fault: cover property ($rose(noBufferFault));
endmodule : ubs_sequencer

/* rtl/ubs_tick_gen.sv */
`timescale 1ns/1ps
`include "ubs_params.svh"
// one-cycle enable pulse every PERIOD cycles
module ubs_tick_gen #(
    parameter int PERIOD = 50000000
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // pulse out
    output logic tick
);
    logic [31:0] count;

    // free running divider
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count == 32'(PERIOD - 1)) begin
            count <= 32'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : ubs_tick_gen

/* sim/ubs_host_model.sv */
`timescale 1ns/1ps
// ------------------------------
// host computer fed by the sequencer
// ------------------------------
module ubs_host_model (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // supply and request from the sequencer
    input wire logic powered,
    input wire logic shutdownRequest,
    // observations
    output logic [7:0] restartCount,
    output logic lostPower
);
    logic wasPowered;
    // a rising supply edge is what reboots a real host
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wasPowered <= 1'h1;
            restartCount <= 8'h00;
            lostPower <= 1'h0;
        end else begin
            wasPowered <= powered;
            if (powered && !wasPowered) begin
                restartCount <= restartCount + 8'h01;
            end
            // sticky: a host cut off mid-shutdown may corrupt its disk
            if (shutdownRequest && !powered) begin
                lostPower <= 1'h1;
            end
        end
    end
endmodule : ubs_host_model

/* sim/ubs_sequencer_tb.sv */
`timescale 1ns/1ps
// ------------------------------
// bench top
// ------------------------------
module ubs_sequencer_tb;
    logic clock = 1'h0, nrst = 1'h0, mLow = 1'h0, cut = 1'h0, flr = 1'h0;
    logic warn = 1'h0, sel = 1'h0, inh = 1'h1;
    logic [15:0] dly = 16'h0005, shut = 16'h0000, wt = 16'h0000;
    logic oe, req, alarm, red, yel, fault, pdn, lost;
    logic [7:0] restarts, r0;
    int mismatches = 0, samples_checked = 0, n, d, de, s, w;
    ubs_sequencer #(.SEC_CYCLES(10), .HALF2_CYCLES(5), .HALF4_CYCLES(3)) u_ubs_sequencer (
        .clock(clock), .nrst(nrst), .mainsBelowActivation(mLow), .batBelowCutoff(cut),
        .batBelowFloor(flr), .batBelowWarn(warn), .hostShutdownSelectorPosition(sel),
        .remoteInhibitContactsClosed(inh), .delaySeconds(dly), .shutdownSeconds(shut),
        .waitSeconds(wt), .outputEnable(oe), .shutdownRequest(req), .alarmContactOpen(alarm),
        .redLed(red), .yellowLed(yel), .noBufferFault(fault), .powerDown(pdn));
    ubs_host_model u_ubs_host_model (.clock(clock), .nrst(nrst), .powered(oe),
        .shutdownRequest(req), .restartCount(restarts), .lostPower(lost));
    // 50 MHz
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // inputs move 2 ns after the edge, clear of sampling
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #2;
    endtask : cyc
    // cycles until an output reaches a level; bounded so a hang shows
    task automatic waitfor(input int sig, input logic val, output int cnt);
        logic cur;
        cnt = 0;
        do begin
            cyc(1);
            cnt++;
            case (sig)
                0: cur = oe;
                1: cur = req;
                2: cur = yel;
                default: cur = pdn;
            endcase
        end while (cur !== val && cnt < 5000);
    endtask : waitfor
    task automatic report_and_stop();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // ------------------------------
    // scenarios
    // ------------------------------
    initial begin
        void'($urandom(42));
        d = $urandom % 9;
        s = 2 + $urandom % 3;
        w = 2 + $urandom % 3;
        de = (d < 5) ? 5 : d; // short delays are raised to the floor
        repeat (5) @(posedge clock);
        #2;
        check({oe, req, alarm, red, fault, pdn}, 6'h20);
        nrst = 1'h1;
        // other party opens the inhibit link
        inh = 1'h0;
        sel = 1'h1;
        cyc(4);
        check({fault, red, alarm}, 3'h7);
        mLow = 1'h1;
        cyc(120);
        check(req, 1'h0);
        mLow = 1'h0;
        inh = 1'h1;
        cyc(4);
        check({fault, red, alarm}, 3'h0);
        // plain buffer, selector elsewhere
        sel = 1'h0;
        mLow = 1'h1;
        // first edge may be the entry, the second may end a partial half period
        waitfor(2, ~yel, n);
        waitfor(2, ~yel, n);
        waitfor(2, ~yel, n);
        check(n, 5);
        warn = 1'h1;
        cyc(8);
        // the first toggle after an arbitrary point is partial
        waitfor(2, ~yel, n);
        waitfor(2, ~yel, n);
        check(n, 3);
        warn = 1'h0;
        cyc(150);
        check({oe, req}, 2'h2);
        cut = 1'h1;
        cyc(4);
        check(oe, 1'h0);
        cut = 1'h0;
        waitfor(2, ~yel, n);
        check(n <= 5, 1);
        cyc(10);
        check({pdn, oe}, 2'h0);
        flr = 1'h1;
        cyc(4);
        check({pdn, oe}, 2'h2);
        mLow = 1'h0;
        flr = 1'h0;
        waitfor(0, 1'h1, n);
        check(n <= 4, 1);
        // host mode, mains back inside the delay
        sel = 1'h1;
        dly = 16'(d);
        shut = 16'(s);
        wt = 16'(w);
        mLow = 1'h1;
        cyc(30);
        mLow = 1'h0;
        cyc(de * 10 + 50);
        check({oe, req}, 2'h2);
        // mains back during the request phase
        r0 = restarts;
        mLow = 1'h1;
        waitfor(1, 1'h1, n);
        mLow = 1'h0;
        check(n >= de * 10 - 8 && n <= de * 10 + 4, 1);
        waitfor(1, 1'h0, n);
        check(n >= s * 10 - 10 && n <= s * 10, 1);
        waitfor(0, 1'h0, n);
        check(n <= 2, 1);
        waitfor(0, 1'h1, n);
        check(n >= w * 10 - 10 && n <= w * 10 + 2, 1);
        // host model sees the supply edge one clock later
        cyc(1);
        check(restarts, r0 + 8'h01);
        // mains stays away through the request phase
        mLow = 1'h1;
        waitfor(3, 1'h1, n);
        check(oe, 1'h0);
        cyc(40);
        check({pdn, oe, req}, 3'h4);
        mLow = 1'h0;
        waitfor(0, 1'h1, n);
        check(n <= 4, 1);
        check(lost, 1'h0);
        report_and_stop();
    end
    // watchdog: scenarios need well under 20000 cycles
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
endmodule : ubs_sequencer_tb
